// *** design/mfr_consts.svh ***
// constants for the register-read instruction executor
`ifndef MFR_CONSTS_SVH
`define MFR_CONSTS_SVH
`define MFR_OPC_PRIMARY 6'h1f
`define MFR_XO_ONE_CRF 10'h013
`define MFR_XO_SPR 10'h153
`define MFR_XO_SEG 10'h253
`define MFR_XO_SEG_IND 10'h273
`define MFR_SPR_MUL_Q 10'h000
`define MFR_SPR_FIX_EXC 10'h001
`define MFR_SPR_CLK_UP 10'h004
`define MFR_SPR_CLK_LO 10'h005
`define MFR_SPR_DOWN_OLD 10'h006
`define MFR_SPR_LINK 10'h008
`define MFR_SPR_LOOP 10'h009
`define MFR_SPR_DOWN_NEW 10'h016
`define MFR_SPR_SYS_A_LO 10'h012
`define MFR_SPR_SYS_A_HI 10'h01b
`define MFR_SPR_SYS_B_LO 10'h110
`define MFR_SPR_SYS_B_HI 10'h113
`define MFR_SPR_SYS_C 10'h11a
`define MFR_SPR_SYS_D_LO 10'h11c
`define MFR_SPR_SYS_D_HI 10'h11d
`define MFR_SPR_SYS_E_LO 10'h210
`define MFR_SPR_SYS_E_HI 10'h21f
`define MFR_ADDR_W 8
`define MFR_REG_CTRL 8'h00
`define MFR_REG_STATUS 8'h04
`define MFR_REG_MASK 8'h08
`define MFR_SEG_BASE_HI 2'h1
`define MFR_CTRL_LEGACY 0
`define MFR_CTRL_USER 1
`define MFR_CTRL_RESET 2'h0
`define MFR_ST_PRIV 0
`define MFR_ST_INVAL 1
`define MFR_ST_DONE 2
`define MFR_ST_RESET 3'h0
`define MFR_MASK_RESET 3'h0
`define MFR_RESP_OKAY 2'h0
`define MFR_RESP_SLVERR 2'h2
`endif

// *** design/mfr_pkg.sv ***
// types for the register-read instruction executor
package mfr_pkg;
   typedef enum logic [2:0] {
      MFR_OP_NONE = 3'h0,
      MFR_OP_CRF = 3'h1,
      MFR_OP_SPR = 3'h2,
      MFR_OP_SEG = 3'h3,
      MFR_OP_SEG_IND = 3'h4
   } mfr_op_e;
   typedef enum logic [1:0] {
      MFR_SPR_USER = 2'h0,
      MFR_SPR_PRIV = 2'h1,
      MFR_SPR_BAD = 2'h2
   } mfr_spr_e;
endpackage

// *** design/mfr_exec.sv ***
// register-read instruction executor with an axi4-lite control slave
// Summary of operation
// - opcode 31 / extended 19 with mask in bits 12-19 reads one condition field
// - each mask bit picks one four-bit condition field into the same gpr bits
// - none of these reads ever modifies the fixed exception register
// - opcode 31 / extended 339 copies the named special register into the gpr
// - ten-bit special id sits in bits 11-20 with its halves swapped
// - ids 1, 8, 9 are unprivileged; listed system ids are privileged
// - down counter is id 22 privileged (newer) or id 6 unprivileged (legacy)
// - ids 0, 4, 5 are accepted only in legacy mode, unprivileged
// - an unlisted special id is an invalid instruction form
// - special register read leaves condition field 0 untouched
// - opcode 31 / extended 595 copies the segment register named in bits 17-19
// - record flag on segment reads makes condition field 0 undefined
// - direct segment read is privileged only in newer mode
// - opcode 31 / extended 627 indirect segment read exists only in legacy mode
// - indirect read picks segment from bits 28-31 of the index into the dest gpr
// - nonzero base gets base plus offset written back, unless base equals dest
//
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "mfr_consts.svh"
module mfr_exec (
   input wire logic clk,
   input wire logic rst,
   input wire logic issue_valid,
   input wire logic [31:0] issue_instr,
   input wire logic [31:0] condition_reg,
   input wire logic [31:0] index_base_value,
   input wire logic [31:0] index_offset_value,
   input wire logic [31:0] fixed_exception_reg,
   input wire logic [31:0] link_reg,
   input wire logic [31:0] loop_count_reg,
   input wire logic [31:0] down_counter_reg,
   input wire logic [31:0] multiply_quotient_reg,
   input wire logic [31:0] clock_upper_reg,
   input wire logic [31:0] clock_lower_reg,
   input wire logic [31:0] sys_spr_value,
   output logic gpr_wr_valid,
   output logic [4:0] gpr_wr_idx,
   output logic [31:0] gpr_wr_data,
   output logic base_wr_valid,
   output logic [4:0] base_wr_idx,
   output logic [31:0] base_wr_data,
   output logic cr0_undefined,
   output logic priv_exception,
   output logic invalid_form,
   output logic op_done,
   output logic irq,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   function automatic mfr_pkg::mfr_op_e mfr_decode(input logic [31:0] ins, input logic legacy);
      mfr_decode = mfr_pkg::MFR_OP_NONE;
      if (ins[31:26] == `MFR_OPC_PRIMARY) begin
         if (ins[10:1] == `MFR_XO_ONE_CRF && ins[20]) begin
            mfr_decode = mfr_pkg::MFR_OP_CRF;
         end else if (ins[10:1] == `MFR_XO_SPR) begin
            mfr_decode = mfr_pkg::MFR_OP_SPR;
         end else if (ins[10:1] == `MFR_XO_SEG) begin
            mfr_decode = mfr_pkg::MFR_OP_SEG;
         end else if (ins[10:1] == `MFR_XO_SEG_IND && legacy) begin
            mfr_decode = mfr_pkg::MFR_OP_SEG_IND;
         end
      end
   endfunction

   // swap the two five-bit halves back into a plain identifier
   function automatic logic [9:0] mfr_spr_id(input logic [31:0] ins);
      mfr_spr_id = {ins[15:11], ins[20:16]};
   endfunction

   function automatic mfr_pkg::mfr_spr_e mfr_spr_class(input logic [9:0] id, input logic legacy);
      mfr_spr_class = mfr_pkg::MFR_SPR_BAD;
      if (id == `MFR_SPR_FIX_EXC || id == `MFR_SPR_LINK || id == `MFR_SPR_LOOP) begin
         mfr_spr_class = mfr_pkg::MFR_SPR_USER;
      end else if ((id >= `MFR_SPR_SYS_A_LO && id <= `MFR_SPR_SYS_A_HI)
            || (id >= `MFR_SPR_SYS_B_LO && id <= `MFR_SPR_SYS_B_HI)
            || id == `MFR_SPR_SYS_C
            || (id >= `MFR_SPR_SYS_D_LO && id <= `MFR_SPR_SYS_D_HI)
            || (id >= `MFR_SPR_SYS_E_LO && id <= `MFR_SPR_SYS_E_HI)) begin
         mfr_spr_class = mfr_pkg::MFR_SPR_PRIV;
      end else if (legacy && (id == `MFR_SPR_MUL_Q || id == `MFR_SPR_CLK_UP
            || id == `MFR_SPR_CLK_LO || id == `MFR_SPR_DOWN_OLD)) begin
         mfr_spr_class = mfr_pkg::MFR_SPR_USER;
      end
   endfunction

   function automatic logic [31:0] mfr_field_mask(input logic [7:0] field_select_mask);
      logic [31:0] m;
      m = 32'h0;
      for (int i = 0; i < 8; i++) begin
         m[4*i +: 4] = {4{field_select_mask[i]}};
      end
      return m;
   endfunction

   function automatic logic [31:0] mfr_strb(input logic [31:0] old, input logic [31:0] dat,
         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = dat[8*i +: 8];
         end
      end
      return r;
   endfunction

   logic [1:0] ctrl;
   logic [2:0] status;
   logic [2:0] mask;
   logic [31:0] seg_reg [16];
   logic aw_held;
   logic w_held;
   logic [7:0] awaddr;
   logic [31:0] wdata;
   logic [3:0] wstrb;
   logic [1:0] next_ctrl;
   logic [2:0] next_status;
   logic [2:0] next_mask;
   logic [31:0] next_seg [16];
   logic next_aw_held;
   logic next_w_held;
   logic [7:0] next_awaddr;
   logic [31:0] next_wdata;
   logic [3:0] next_wstrb;
   logic next_bvalid;
   logic [1:0] next_bresp;
   logic next_rvalid;
   logic [31:0] next_rdata;
   logic [1:0] next_rresp;
   logic next_irq;
   logic [2:0] ev_set;
   logic legacy;
   logic user_mode;

   assign legacy = ctrl[`MFR_CTRL_LEGACY];
   assign user_mode = ctrl[`MFR_CTRL_USER];

   // execution: one instruction per cycle, results one edge after issue
   logic next_gpr_wr_valid;
   logic [4:0] next_gpr_wr_idx;
   logic [31:0] next_gpr_wr_data;
   logic next_base_wr_valid;
   logic [4:0] next_base_wr_idx;
   logic [31:0] next_base_wr_data;
   logic next_cr0_undefined;
   logic next_priv_exception;
   logic next_invalid_form;
   logic next_op_done;

   always_comb begin
      mfr_pkg::mfr_op_e op;
      mfr_pkg::mfr_spr_e cls;
      logic [9:0] id;
      logic [31:0] sum;
      logic need_priv;
      op = mfr_decode(issue_instr, legacy);
      id = mfr_spr_id(issue_instr);
      cls = mfr_spr_class(id, legacy);
      sum = 32'(index_base_value + index_offset_value);
      need_priv = 1'b0;
      next_gpr_wr_valid = 1'b0;
      next_gpr_wr_idx = issue_instr[25:21];
      next_gpr_wr_data = 32'h0;
      next_base_wr_valid = 1'b0;
      next_base_wr_idx = issue_instr[20:16];
      next_base_wr_data = sum;
      next_cr0_undefined = 1'b0;
      next_priv_exception = 1'b0;
      next_invalid_form = 1'b0;
      next_op_done = 1'b0;
      // no path here writes the fixed exception register
      if (issue_valid && op != mfr_pkg::MFR_OP_NONE) begin
         next_op_done = 1'b1;
         next_gpr_wr_valid = 1'b1;
         unique case (op)
            mfr_pkg::MFR_OP_CRF: begin
               // one mask bit is expected; extra bits merge fields
               next_gpr_wr_data = condition_reg
                  & mfr_field_mask(issue_instr[19:12]);
            end
            mfr_pkg::MFR_OP_SPR: begin
               need_priv = (cls == mfr_pkg::MFR_SPR_PRIV);
               unique case (id)
                  `MFR_SPR_FIX_EXC: next_gpr_wr_data = fixed_exception_reg;
                  `MFR_SPR_LINK: next_gpr_wr_data = link_reg;
                  `MFR_SPR_LOOP: next_gpr_wr_data = loop_count_reg;
                  `MFR_SPR_DOWN_NEW: next_gpr_wr_data = down_counter_reg;
                  `MFR_SPR_DOWN_OLD: next_gpr_wr_data = down_counter_reg;
                  `MFR_SPR_MUL_Q: next_gpr_wr_data = multiply_quotient_reg;
                  `MFR_SPR_CLK_UP: next_gpr_wr_data = clock_upper_reg;
                  `MFR_SPR_CLK_LO: next_gpr_wr_data = clock_lower_reg;
                  default: next_gpr_wr_data = sys_spr_value;
               endcase
               if (cls == mfr_pkg::MFR_SPR_BAD) begin
                  next_gpr_wr_valid = 1'b0;
                  next_invalid_form = 1'b1;
               end
               // cr0 stays untouched for this form
            end
            mfr_pkg::MFR_OP_SEG: begin
               need_priv = !legacy;
               next_gpr_wr_data = seg_reg[{1'b0, issue_instr[19:17]}];
               next_cr0_undefined = issue_instr[0];
            end
            mfr_pkg::MFR_OP_SEG_IND: begin
               if (issue_instr[20:16] == 5'h0) begin
                  next_gpr_wr_data = seg_reg[index_offset_value[31:28]];
               end else begin
                  next_gpr_wr_data = seg_reg[sum[31:28]];
                  next_base_wr_valid = (issue_instr[20:16] != issue_instr[25:21]);
               end
               next_cr0_undefined = issue_instr[0];
            end
            default: next_gpr_wr_valid = 1'b0;
         endcase
         if (need_priv && user_mode) begin
            next_gpr_wr_valid = 1'b0;
            next_base_wr_valid = 1'b0;
            next_cr0_undefined = 1'b0;
            next_priv_exception = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         gpr_wr_valid <= 1'b0;
         gpr_wr_idx <= 5'h0;
         gpr_wr_data <= 32'h0;
         base_wr_valid <= 1'b0;
         base_wr_idx <= 5'h0;
         base_wr_data <= 32'h0;
         cr0_undefined <= 1'b0;
         priv_exception <= 1'b0;
         invalid_form <= 1'b0;
         op_done <= 1'b0;
      end else begin
         gpr_wr_valid <= next_gpr_wr_valid;
         gpr_wr_idx <= next_gpr_wr_idx;
         gpr_wr_data <= next_gpr_wr_data;
         base_wr_valid <= next_base_wr_valid;
         base_wr_idx <= next_base_wr_idx;
         base_wr_data <= next_base_wr_data;
         cr0_undefined <= next_cr0_undefined;
         priv_exception <= next_priv_exception;
         invalid_form <= next_invalid_form;
         op_done <= next_op_done;
      end
   end

   // register slave: address and data held separately, response after both
   always_comb begin
      logic do_wr;
      logic aw_take;
      logic w_take;
      logic ar_take;
      logic [31:0] clr;
      logic [31:0] upd;
      upd = 32'h0;
      aw_take = s_axi_awvalid && s_axi_awready;
      w_take = s_axi_wvalid && s_axi_wready;
      ar_take = s_axi_arvalid && s_axi_arready;
      do_wr = aw_held && w_held && !s_axi_bvalid;
      clr = mfr_strb(32'h0, wdata, wstrb);
      next_ctrl = ctrl;
      next_mask = mask;
      next_seg = seg_reg;
      next_aw_held = aw_held || aw_take;
      next_w_held = w_held || w_take;
      next_awaddr = aw_take ? s_axi_awaddr : awaddr;
      next_wdata = w_take ? s_axi_wdata : wdata;
      next_wstrb = w_take ? s_axi_wstrb : wstrb;
      next_bvalid = s_axi_bvalid && !s_axi_bready;
      next_bresp = s_axi_bresp;
      next_rvalid = s_axi_rvalid && !s_axi_rready;
      next_rdata = s_axi_rdata;
      next_rresp = s_axi_rresp;
      ev_set = 3'h0;
      ev_set[`MFR_ST_PRIV] = next_priv_exception;
      ev_set[`MFR_ST_INVAL] = next_invalid_form;
      ev_set[`MFR_ST_DONE] = next_op_done;
      if (!do_wr || awaddr != `MFR_REG_STATUS) begin
         clr = 32'h0;
      end
      if (do_wr) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = `MFR_RESP_OKAY;
         if (awaddr[7:6] == `MFR_SEG_BASE_HI && awaddr[1:0] == 2'h0) begin
            next_seg[awaddr[5:2]] = mfr_strb(seg_reg[awaddr[5:2]], wdata, wstrb);
         end else if (awaddr == `MFR_REG_CTRL) begin
            upd = mfr_strb({30'h0, ctrl}, wdata, wstrb);
            next_ctrl = upd[1:0];
         end else if (awaddr == `MFR_REG_MASK) begin
            upd = mfr_strb({29'h0, mask}, wdata, wstrb);
            next_mask = upd[2:0];
         end else if (awaddr != `MFR_REG_STATUS) begin
            next_bresp = `MFR_RESP_SLVERR;
         end
      end
      // a new event wins over a clear in the same cycle
      next_status = (status & ~clr[2:0]) | ev_set;
      if (ar_take) begin
         next_rvalid = 1'b1;
         next_rresp = `MFR_RESP_OKAY;
         if (s_axi_araddr[7:6] == `MFR_SEG_BASE_HI && s_axi_araddr[1:0] == 2'h0) begin
            next_rdata = seg_reg[s_axi_araddr[5:2]];
         end else if (s_axi_araddr == `MFR_REG_CTRL) begin
            next_rdata = {30'h0, ctrl};
         end else if (s_axi_araddr == `MFR_REG_STATUS) begin
            next_rdata = {29'h0, status};
         end else if (s_axi_araddr == `MFR_REG_MASK) begin
            next_rdata = {29'h0, mask};
         end else begin
            next_rdata = 32'h0;
            next_rresp = `MFR_RESP_SLVERR;
         end
      end
      next_irq = |(next_status & next_mask);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl <= `MFR_CTRL_RESET;
         status <= `MFR_ST_RESET;
         mask <= `MFR_MASK_RESET;
         for (int i = 0; i < 16; i++) begin
            seg_reg[i] <= 32'h0;
         end
         aw_held <= 1'b0;
         w_held <= 1'b0;
         awaddr <= 8'h0;
         wdata <= 32'h0;
         wstrb <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= 2'h0;
         irq <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         status <= next_status;
         mask <= next_mask;
         seg_reg <= next_seg;
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         awaddr <= next_awaddr;
         wdata <= next_wdata;
         wstrb <= next_wstrb;
         s_axi_awready <= !next_aw_held;
         s_axi_wready <= !next_w_held;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp <= next_bresp;
         s_axi_arready <= !next_rvalid;
         s_axi_rvalid <= next_rvalid;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rresp;
         irq <= next_irq;
      end
   end

   a_crf_field: assert property (@(posedge clk) disable iff (rst)
      issue_valid && mfr_decode(issue_instr, legacy) == mfr_pkg::MFR_OP_CRF
      |=> gpr_wr_valid && gpr_wr_data == (($past(condition_reg))
          & mfr_field_mask($past(issue_instr[19:12]))))
      else $error("one-field read result wrong");

   a_crf_zero_rest: assert property (@(posedge clk) disable iff (rst)
      issue_valid && mfr_decode(issue_instr, legacy) == mfr_pkg::MFR_OP_CRF
      |=> (gpr_wr_data & ~mfr_field_mask($past(issue_instr[19:12]))) == 32'h0)
      else $error("bits outside field not zero");

   a_spr_link: assert property (@(posedge clk) disable iff (rst)
      issue_valid && mfr_decode(issue_instr, legacy) == mfr_pkg::MFR_OP_SPR
      && mfr_spr_id(issue_instr) == `MFR_SPR_LINK
      |=> gpr_wr_valid && !priv_exception && gpr_wr_data == $past(link_reg))
      else $error("link register read wrong");

   a_spr_invalid: assert property (@(posedge clk) disable iff (rst)
      issue_valid && mfr_decode(issue_instr, legacy) == mfr_pkg::MFR_OP_SPR
      && mfr_spr_class(mfr_spr_id(issue_instr), legacy) == mfr_pkg::MFR_SPR_BAD
      |=> invalid_form && !gpr_wr_valid ##1 status[`MFR_ST_INVAL])
      else $error("unlisted id not flagged invalid");

   a_legacy_only_ids: assert property (@(posedge clk) disable iff (rst)
      issue_valid && !legacy && mfr_decode(issue_instr, legacy) == mfr_pkg::MFR_OP_SPR
      && mfr_spr_id(issue_instr) == `MFR_SPR_MUL_Q
      |=> invalid_form)
      else $error("legacy-only id accepted in newer mode");

   a_spr_keeps_cr0: assert property (@(posedge clk) disable iff (rst)
      issue_valid && mfr_decode(issue_instr, legacy) == mfr_pkg::MFR_OP_SPR
      |=> !cr0_undefined)
      else $error("special read touched cr0");

   a_seg_record: assert property (@(posedge clk) disable iff (rst)
      issue_valid && legacy && issue_instr[0]
      && mfr_decode(issue_instr, legacy) == mfr_pkg::MFR_OP_SEG
      |=> cr0_undefined && gpr_wr_valid)
      else $error("record flag did not mark cr0");

   a_priv_blocked: assert property (@(posedge clk) disable iff (rst)
      issue_valid && user_mode && !legacy
      && mfr_decode(issue_instr, legacy) == mfr_pkg::MFR_OP_SEG
      |=> priv_exception && !gpr_wr_valid ##1 status[`MFR_ST_PRIV])
      else $error("privileged read not blocked");

   a_base_writeback: assert property (@(posedge clk) disable iff (rst)
      issue_valid && mfr_decode(issue_instr, legacy) == mfr_pkg::MFR_OP_SEG_IND
      && issue_instr[20:16] != 5'h0 && issue_instr[20:16] != issue_instr[25:21]
      |=> base_wr_valid && base_wr_data == $past(index_base_value) + $past(index_offset_value))
      else $error("base write-back missing or wrong");

   a_base_skip_same: assert property (@(posedge clk) disable iff (rst)
      issue_valid && mfr_decode(issue_instr, legacy) == mfr_pkg::MFR_OP_SEG_IND
      && issue_instr[20:16] == issue_instr[25:21]
      |=> !base_wr_valid)
      else $error("base written when equal to dest");

   a_ind_newer_none: assert property (@(posedge clk) disable iff (rst)
      issue_valid && !legacy && issue_instr[31:26] == `MFR_OPC_PRIMARY
      && issue_instr[10:1] == `MFR_XO_SEG_IND
      |=> !op_done && !gpr_wr_valid)
      else $error("indirect segment read ran in newer mode");
endmodule

// *** sim/mfr_core_model.sv ***
// core-side model that supplies special register values for read instructions
`timescale 1ns/1ps
module mfr_core_model (
   input wire logic [31:0] issue_instr,
   output logic [31:0] fixed_exception_reg,
   output logic [31:0] link_reg,
   output logic [31:0] loop_count_reg,
   output logic [31:0] down_counter_reg,
   output logic [31:0] multiply_quotient_reg,
   output logic [31:0] clock_upper_reg,
   output logic [31:0] clock_lower_reg,
   output logic [31:0] sys_spr_value
);
   assign fixed_exception_reg = 32'h1000_0001;
   assign link_reg = 32'h1000_0008;
   assign loop_count_reg = 32'h1000_0009;
   assign down_counter_reg = 32'h1000_0016;
   assign multiply_quotient_reg = 32'h1000_0000;
   assign clock_upper_reg = 32'h1000_0004;
   assign clock_lower_reg = 32'h1000_0005;
   // system register value tagged with the swapped-halves id of the presented word
   assign sys_spr_value = {22'h168000, issue_instr[15:11], issue_instr[20:16]};
endmodule

// *** sim/mfr_exec_tb.sv ***
// self-checking bench for the register-read instruction executor
`timescale 1ns/1ps
`include "mfr_consts.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
   $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module mfr_exec_tb;
   logic clk, rst, iv, awv, wv, bry, arv, rry, gv, bwv, cru, pe, ifm, done, irq;
   logic awr, wr, bvl, arr, rvl;
   logic [31:0] ins, cnd, bv, ov, wd, gd, bd, rd, fxe, lnk, lpc, dnc, mul, cu, cl, sys;
   logic [31:0] seg [16];
   logic [7:0] awa, ara;
   logic [4:0] gi, bi;
   logic [1:0] brs, rrs;
   logic [78:0] q [$];
   int miscompares, cmp_count;
   int nv[$] = '{1, 8, 9, 22, 18, 27, 272, 275, 282, 284, 285, 528, 543};
   int nbad[$] = '{0, 4, 5, 6, 2, 544};
   int lv[$] = '{0, 4, 5, 6, 1, 22};
   mfr_core_model i_core (.issue_instr(ins), .fixed_exception_reg(fxe), .link_reg(lnk),
      .loop_count_reg(lpc), .down_counter_reg(dnc), .multiply_quotient_reg(mul),
      .clock_upper_reg(cu), .clock_lower_reg(cl), .sys_spr_value(sys));
   mfr_exec i_dut (.clk(clk), .rst(rst), .issue_valid(iv), .issue_instr(ins),
      .condition_reg(cnd), .index_base_value(bv), .index_offset_value(ov),
      .fixed_exception_reg(fxe), .link_reg(lnk), .loop_count_reg(lpc),
      .down_counter_reg(dnc), .multiply_quotient_reg(mul),
      .clock_upper_reg(cu), .clock_lower_reg(cl), .sys_spr_value(sys), .gpr_wr_valid(gv),
      .gpr_wr_idx(gi), .gpr_wr_data(gd), .base_wr_valid(bwv), .base_wr_idx(bi), .base_wr_data(bd),
      .cr0_undefined(cru), .priv_exception(pe), .invalid_form(ifm), .op_done(done), .irq(irq),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(brs),
      .s_axi_bvalid(bvl), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rrs), .s_axi_rvalid(rvl),
      .s_axi_rready(rry));
   initial begin
      clk = 0;
      forever #20 clk = ~clk;
   end
   function automatic logic [31:0] mk(input logic [4:0] t, input logic [9:0] m,
      input logic [9:0] xo, input logic rec);
      return {`MFR_OPC_PRIMARY, t, m, xo, rec};
   endfunction
   function automatic logic [9:0] sw(input int id);
      return {id[4:0], id[9:5]};
   endfunction
   function automatic logic [31:0] spv(input int id);
      case (id)
         6, 22: return 32'h1000_0016;
         0, 1, 4, 5, 8, 9: return 32'h1000_0000 | id;
         default: return 32'h5a00_0000 | id;
      endcase
   endfunction
   task automatic iss(input logic [31:0] i, input logic [78:0] e, input logic [31:0] c = 0,
      input logic [31:0] b = 0, input logic [31:0] o = 0);
      @(posedge clk);
      iv <= 1;
      ins <= i;
      cnd <= c;
      bv <= b;
      ov <= o;
      if (e !== '1) q.push_back(e);
   endtask
   task automatic idle;
      @(posedge clk);
      iv <= 0;
   endtask
   task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ad, dd;
      ad = 0;
      dd = 0;
      @(posedge clk);
      awa <= a;
      wd <= d;
      awv <= 1;
      wv <= 1;
      bry <= 1;
      while (!(ad && dd)) begin
         @(posedge clk);
         if (!ad && awr === 1'b1) begin
            ad = 1;
            awv <= 0;
         end
         if (!dd && wr === 1'b1) begin
            dd = 1;
            wv <= 0;
         end
      end
      while (bvl !== 1'b1) @(posedge clk);
      bry <= 0;
      `CHK(brs, er)
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge clk);
      ara <= a;
      arv <= 1;
      rry <= 1;
      do @(posedge clk); while (arr !== 1'b1);
      arv <= 0;
      do @(posedge clk); while (rvl !== 1'b1);
      rry <= 0;
      `CHK(rd, d)
      `CHK(rrs, er)
   endtask
   task automatic ind(input logic [4:0] ba, input logic [4:0] ds, input logic rec);
      logic [31:0] b, o, ix;
      logic wb;
      b = $urandom;
      o = $urandom;
      ix = (ba != 0) ? b + o : o;
      wb = (ba != 0) && (ba != ds);
      iss(mk(ds, {ba, 5'h3}, `MFR_XO_SEG_IND, rec), {1'b1, ds, seg[ix[31:28]], 2'b00, rec, wb,
         wb ? ba : 5'h0, wb ? b + o : 32'h0}, 0, b, o);
   endtask
   task automatic results;
      $display("counts: %0d compares, %0d mismatches", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   always @(posedge clk) begin
      logic [78:0] g, e;
      if (done === 1'b1) begin
         e = q.pop_front();
         g = {gv, gv === 1'b1 ? gi : 5'h0, gv === 1'b1 ? gd : 32'h0, pe, ifm, cru, bwv,
            bwv === 1'b1 ? bi : 5'h0, bwv === 1'b1 ? bd : 32'h0};
         `CHK(g, e)
      end
   end
   initial begin
      #2_000_000;
      miscompares++;
      results;
   end
   initial begin
      logic [31:0] r;
      void'($urandom(54));
      {rst, iv, awv, wv, bry, arv, rry} = 7'h40;
      {ins, cnd, bv, ov, wd, awa, ara} = '0;
      repeat (6) @(posedge clk);
      rst <= 0;
      rdc(`MFR_REG_CTRL, 0, `MFR_RESP_OKAY);
      rdc(`MFR_REG_STATUS, 0, `MFR_RESP_OKAY);
      rdc(`MFR_REG_MASK, 0, `MFR_RESP_OKAY);
      rdc(8'h20, 0, `MFR_RESP_SLVERR);
      wrc(8'h30, 1, `MFR_RESP_SLVERR);
      for (int n = 0; n < 16; n++) begin
         seg[n] = $urandom;
         wrc(8'h40 + 8'(4 * n), seg[n], `MFR_RESP_OKAY);
      end
      rdc(8'h7c, seg[15], `MFR_RESP_OKAY);
      $display("test registers done");
      for (int k = 0; k < 8; k++) begin
         r = $urandom;
         iss(mk(5'(k), {1'b1, 8'h80 >> k, 1'b0}, `MFR_XO_ONE_CRF, 0),
            {1'b1, 5'(k), r & (32'hf000_0000 >> (4 * k)), 41'h0}, r);
      end
      iss(mk(1, {1'b0, 8'h80, 1'b0}, `MFR_XO_ONE_CRF, 0), '1);
      iss({6'h1e, 26'h0}, '1);
      iss(mk(2, 10'h0, `MFR_XO_SEG_IND, 0), '1);
      foreach (nv[k])
         iss(mk(5'(k), sw(nv[k]), `MFR_XO_SPR, 1),
            {1'b1, 5'(k), spv(nv[k]), 41'h0});
      foreach (nbad[k])
         iss(mk(5'(k), sw(nbad[k]), `MFR_XO_SPR, 0),
            {38'h0, 4'b0100, 37'h0});
      for (int k = 0; k < 8; k++)
         iss(mk(5'(k), {1'b0, 3'(k), 6'h0}, `MFR_XO_SEG, k[0]),
            {1'b1, 5'(k), seg[k], 2'b00, k[0], 38'h0});
      idle;
      $display("test newer mode done");
      wrc(`MFR_REG_CTRL, 1, `MFR_RESP_OKAY);
      foreach (lv[k])
         iss(mk(5'(k), sw(lv[k]), `MFR_XO_SPR, 0),
            {1'b1, 5'(k), spv(lv[k]), 41'h0});
      ind(0, 4, 0);
      ind(6, 6, 1);
      ind(7, 9, 0);
      ind(31, 2, 1);
      idle;
      wrc(`MFR_REG_CTRL, 2, `MFR_RESP_OKAY);
      iss(mk(3, sw(22), `MFR_XO_SPR, 0), {38'h0, 4'b1000, 37'h0});
      iss(mk(3, sw(272), `MFR_XO_SPR, 0), {38'h0, 4'b1000, 37'h0});
      iss(mk(4, sw(8), `MFR_XO_SPR, 0), {1'b1, 5'd4, spv(8), 41'h0});
      iss(mk(5, {1'b0, 3'd5, 6'h0}, `MFR_XO_SEG, 1), {38'h0, 4'b1000, 37'h0});
      idle;
      wrc(`MFR_REG_CTRL, 3, `MFR_RESP_OKAY);
      iss(mk(5, {1'b0, 3'd5, 6'h0}, `MFR_XO_SEG, 1),
         {1'b1, 5'd5, seg[5], 4'b0010, 37'h0});
      iss(mk(6, sw(6), `MFR_XO_SPR, 0), {1'b1, 5'd6, spv(6), 41'h0});
      idle;
      $display("test legacy and user modes done");
      `CHK(irq, 1'b0)
      wrc(`MFR_REG_MASK, 4, `MFR_RESP_OKAY);
      repeat (3) @(posedge clk);
      `CHK(irq, 1'b1)
      wrc(`MFR_REG_STATUS, 4, `MFR_RESP_OKAY);
      repeat (3) @(posedge clk);
      `CHK(irq, 1'b0)
      rdc(`MFR_REG_STATUS, 3, `MFR_RESP_OKAY);
      wrc(`MFR_REG_STATUS, 3, `MFR_RESP_OKAY);
      rdc(`MFR_REG_STATUS, 0, `MFR_RESP_OKAY);
      $display("test interrupt done");
      `CHK(q.size(), 0)
      results;
   end
endmodule
